/* File: logic/fault_propagation_sync_ctrl.v */
`timescale 1ns/1ps
`include "fault_sync_consts.vh"

// Contract
// - a propagating fault pulls the shared fault line low.
// - a low fault line from another converter starts our turn-off, same type.
// - the turn-off type is coded into the line's high-to-low transition; here it is the line level at the two sync falling edges after it.
// - our drive on the fault line changes only at sync line falling edges.
// - without propagation we turn off alone and leave the fault line released.
// - non-latching faults retry start-up every 130 ms.
// - the 130 ms retry ignores any programmed turn-off delay.
// - propagation is chosen per fault type in a read/write register.
// - overcurrent armed above prebias, fast off, propagates only as critical.
// - frequency 500 kHz or 1 MHz; config writes only while turned off.
// - switching starts in step with the sync line falling edge.
// - each converter picks its own frequency, all locked to the sync line.
// - pwm start lags the sync edge by interleave code times 22.5 degrees.
// - frequency bit 5: zero is 500 kHz, one is 1000 kHz.
// - phase count bits 7:6 select one to four pwm phases.
// - config bit 4 always reads zero.
// - active fault reads zero; writing one clears a latched fault.
// - sequenced ramps down, critical opens both, emergency closes low side.
// - latching fault stays off until bit cleared or turn-on recycled.
module fault_propagation_sync_ctrl #(
	parameter RETRY_CYCLES = `RETRY_MS * `CLK_KHZ,
	parameter CNT_W = 25,
	parameter SYNC_CYCLES = `CLK_KHZ / `SYNC_KHZ
)
(
	// clock and reset
	input wire clk_sys,
	input wire sys_rst,
	input wire clk_en,
	// link pins
	input wire sync_line,
	input wire fault_line_i,
	output reg fault_line_o_q,
	output reg fault_line_oe_n_q,
	// converter condition inputs
	input wire turn_on_cmd,
	input wire prebias_exceeded,
	input wire tracking_fault,
	input wire overtemp_fault,
	input wire overcurrent_fault,
	input wire undervoltage_fault,
	input wire overvoltage_error,
	input wire temp_warning,
	input wire power_good_warning,
	// register port
	input wire reg_wr,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata_q,
	// converter control
	output reg conv_on_q,
	output reg [1:0] shutdown_type_q,
	output reg pwm_start_q,
	output reg [3:0] pwm_phase_en_q,
	output reg switch_freq_1mhz_q
);

	// ****************************************
	// constants
	// ****************************************
	localparam [31:0] STEP_FULL = SYNC_CYCLES / `PHASE_STEPS;
	localparam [31:0] HALF_FULL = SYNC_CYCLES / 2;
	localparam [31:0] RETRY_FULL = RETRY_CYCLES - 1;
	localparam [9:0] STEP_CYC = STEP_FULL[9:0];
	localparam [9:0] HALF_CYC = HALF_FULL[9:0];
	localparam [CNT_W-1:0] RETRY_LAST = RETRY_FULL[CNT_W-1:0];
	localparam NSYNC = 11;

	localparam [2:0] S_OFF = 3'h0;
	localparam [2:0] S_RUN = 3'h1;
	localparam [2:0] S_LATCHED = 3'h2;
	localparam [2:0] S_RETRY = 3'h3;
	localparam [2:0] S_REMOTE = 3'h4;

	localparam [1:0] D_IDLE = 2'h0;
	localparam [1:0] D_B0 = 2'h1;
	localparam [1:0] D_B1 = 2'h2;
	localparam [1:0] D_HOLD = 2'h3;

	localparam [1:0] L_IDLE = 2'h0;
	localparam [1:0] L_B0 = 2'h1;
	localparam [1:0] L_B1 = 2'h2;

	// ****************************************
	// functions
	// ****************************************
	// most severe tripping fault decides the type
	function [1:0] off_type_of;
		input [7:0] trip;
		input [7:0] cfg;
		begin
			if (trip[`BIT_OV])
				off_type_of = cfg[`BIT_OV] ? `OFF_EMERGENCY : `OFF_CRITICAL;
			else if (trip[`BIT_OC] | trip[`BIT_TR])
				off_type_of = `OFF_CRITICAL;
			else if (trip[`BIT_OT])
				off_type_of = cfg[`BIT_OT] ? `OFF_CRITICAL : `OFF_SEQUENCED;
			else
				off_type_of = cfg[`BIT_UV] ? `OFF_CRITICAL : `OFF_SEQUENCED;
		end
	endfunction

	function [3:0] phase_enables;
		input [1:0] code;
		begin
			case (code)
				2'h0: phase_enables = 4'h1;
				2'h1: phase_enables = 4'h5;
				2'h2: phase_enables = 4'h7;
				default: phase_enables = 4'hf;
			endcase
		end
	endfunction

	// ****************************************
	// input synchronisers
	// ****************************************
	wire [NSYNC-1:0] raw_in;
	reg [NSYNC-1:0] meta_q;
	reg [NSYNC-1:0] sync_q;
	assign raw_in = {sync_line, fault_line_i, turn_on_cmd, prebias_exceeded,
		tracking_fault, overtemp_fault, overcurrent_fault, undervoltage_fault,
		overvoltage_error, temp_warning, power_good_warning};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1)
		begin : g_sync
			always @(posedge clk_sys or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					meta_q[gi] <= 1'b0;
					sync_q[gi] <= 1'b0;
				end
				else if (clk_en)
				begin
					meta_q[gi] <= raw_in[gi];
					sync_q[gi] <= meta_q[gi];
				end
			end
		end
	endgenerate

	wire s_sync = sync_q[10];
	wire s_fault = sync_q[9];
	wire s_on = sync_q[8];
	reg sync_prev_q;
	wire fall = sync_prev_q & ~s_sync;

	// detected faults at status bit positions
	wire [7:0] det;
	assign det = {2'b00, sync_q[6], sync_q[5], sync_q[4] & sync_q[7], sync_q[3], sync_q[2], 1'b0};

	// ****************************************
	// registers and state
	// ****************************************
	reg [7:0] interleave_q;
	reg [7:0] status_q;
	reg [7:0] propagate_q;
	reg [7:0] latching_q;
	reg [7:0] offtype_q;
	reg [2:0] state_q;
	reg [CNT_W-1:0] retry_cnt_q;
	reg drv_req_q;
	reg [1:0] drv_type_q;
	reg [1:0] drv_state_q;
	reg [1:0] lst_state_q;
	reg line_level_q;
	reg b0_q;
	reg remote_q;
	reg [1:0] remote_type_q;
	reg [9:0] ph_cnt_q;

	wire running = (state_q == S_RUN);
	wire [7:0] trip = det & {8{running}};
	wire any_trip = |trip;
	wire [1:0] trip_type = off_type_of(trip, offtype_q);
	wire wr_status = reg_wr & (reg_addr == `ADDR_STATUS);
	wire [7:0] status_clr = wr_status ? reg_wdata : 8'h00;

	// ****************************************
	// register writes
	// ****************************************
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			interleave_q <= `INTERLEAVE_RESET;
			propagate_q <= `PROPAGATE_RESET;
			latching_q <= `LATCHING_RESET;
			offtype_q <= `OFFTYPE_RESET;
		end
		else if (clk_en && reg_wr)
		begin
			// frozen while switching so the pwm never glitches
			if (reg_addr == `ADDR_INTERLEAVE && !conv_on_q)
				interleave_q <= reg_wdata & `INT_WRITE_MASK;
			if (reg_addr == `ADDR_PROPAGATE)
				propagate_q <= reg_wdata;
			if (reg_addr == `ADDR_LATCHING)
				latching_q <= reg_wdata;
			if (reg_addr == `ADDR_OFFTYPE)
				offtype_q <= reg_wdata;
		end
	end

	// ****************************************
	// protection state machine
	// ****************************************
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q <= S_OFF;
			status_q <= `STATUS_RESET;
			retry_cnt_q <= {CNT_W{1'b0}};
			drv_req_q <= 1'b0;
			drv_type_q <= `OFF_SEQUENCED;
			conv_on_q <= 1'b0;
			shutdown_type_q <= `OFF_SEQUENCED;
		end
		else if (clk_en)
		begin
			// hardware clearing to zero beats a software write of one
			status_q <= (status_q | status_clr) & ~trip;
			case (state_q)
				S_OFF:
				begin
					// wait for the code to finish so we never pull while switching
					if (s_on && line_level_q && !drv_req_q && drv_state_q == D_IDLE)
					begin
						state_q <= S_RUN;
						conv_on_q <= 1'b1;
					end
				end
				S_RUN:
				begin
					if (any_trip)
					begin
						conv_on_q <= 1'b0;
						shutdown_type_q <= trip_type;
						retry_cnt_q <= {CNT_W{1'b0}};
						if (|(trip & propagate_q))
						begin
							drv_req_q <= 1'b1;
							drv_type_q <= trip_type;
						end
						// otherwise the line stays released
						state_q <= (|(trip & latching_q)) ? S_LATCHED : S_RETRY;
					end
					else if (remote_q)
					begin
						conv_on_q <= 1'b0;
						shutdown_type_q <= remote_type_q;
						state_q <= S_REMOTE;
					end
					else if (!s_on)
					begin
						conv_on_q <= 1'b0;
						shutdown_type_q <= `OFF_SEQUENCED;
						state_q <= S_OFF;
					end
				end
				S_LATCHED:
				begin
					if (!s_on || (&(status_q[`BIT_TR:`BIT_OV] | status_clr[`BIT_TR:`BIT_OV])))
					begin
						drv_req_q <= 1'b0;
						state_q <= S_OFF;
					end
				end
				S_RETRY:
				begin
					// counted from the trip, not from the end of ramp-down
					if (retry_cnt_q == RETRY_LAST)
					begin
						drv_req_q <= 1'b0;
						status_q[`BIT_TR:`BIT_OV] <= {5{1'b1}};
						state_q <= S_OFF;
					end
					else
						retry_cnt_q <= retry_cnt_q + 1'b1;
				end
				S_REMOTE:
				begin
					if (fall && s_fault && lst_state_q == L_IDLE)
						state_q <= S_OFF;
				end
				default: state_q <= S_OFF;
			endcase
		end
	end

	// ****************************************
	// fault line driver
	// ****************************************
	// code: edge 0 low, edge 1 high for critical, edge 2 high for emergency
	wire code_b0 = (drv_type_q == `OFF_CRITICAL);
	wire code_b1 = (drv_type_q == `OFF_EMERGENCY);

	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			drv_state_q <= D_IDLE;
			fault_line_oe_n_q <= 1'b1;
			fault_line_o_q <= 1'b0;
			sync_prev_q <= 1'b0;
		end
		else if (clk_en)
		begin
			sync_prev_q <= s_sync;
			fault_line_o_q <= 1'b0;
			if (fall)
			begin
				case (drv_state_q)
					D_IDLE:
					begin
						if (drv_req_q)
						begin
							fault_line_oe_n_q <= 1'b0;
							drv_state_q <= D_B0;
						end
					end
					D_B0:
					begin
						fault_line_oe_n_q <= code_b0;
						drv_state_q <= D_B1;
					end
					D_B1:
					begin
						fault_line_oe_n_q <= code_b1;
						drv_state_q <= D_HOLD;
					end
					D_HOLD:
					begin
						fault_line_oe_n_q <= ~drv_req_q;
						if (!drv_req_q)
							drv_state_q <= D_IDLE;
					end
					default: drv_state_q <= D_IDLE;
				endcase
			end
		end
	end

	// ****************************************
	// fault line listener
	// ****************************************
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			lst_state_q <= L_IDLE;
			line_level_q <= 1'b0;
			b0_q <= 1'b0;
			remote_q <= 1'b0;
			remote_type_q <= `OFF_SEQUENCED;
		end
		else if (clk_en)
		begin
			remote_q <= 1'b0;
			if (fall)
			begin
				line_level_q <= s_fault;
				case (lst_state_q)
					L_IDLE:
					begin
						// our own drive is not a remote event
						if (line_level_q && !s_fault && drv_state_q == D_IDLE && !drv_req_q)
							lst_state_q <= L_B0;
					end
					L_B0:
					begin
						b0_q <= s_fault;
						lst_state_q <= L_B1;
					end
					L_B1:
					begin
						remote_q <= 1'b1;
						remote_type_q <= b0_q ? `OFF_CRITICAL :
							(s_fault ? `OFF_EMERGENCY : `OFF_SEQUENCED);
						lst_state_q <= L_IDLE;
					end
					default: lst_state_q <= L_IDLE;
				endcase
			end
		end
	end

	// ****************************************
	// pwm timing
	// ****************************************
	wire [9:0] lag = interleave_q[`INT_STEP_MSB:`INT_STEP_LSB] * STEP_CYC;
	wire [9:0] lag2 = (lag >= HALF_CYC) ? lag - HALF_CYC : lag + HALF_CYC;
	wire freq_hi = interleave_q[`INT_FREQ];

	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ph_cnt_q <= 10'h000;
			pwm_start_q <= 1'b0;
			pwm_phase_en_q <= 4'h0;
			switch_freq_1mhz_q <= 1'b0;
		end
		else if (clk_en)
		begin
			// counter restarts on each sync falling edge
			if (fall)
				ph_cnt_q <= 10'h000;
			else if (ph_cnt_q != 10'h3ff)
				ph_cnt_q <= ph_cnt_q + 10'h001;
			pwm_start_q <= conv_on_q && ((ph_cnt_q == lag) || (freq_hi && ph_cnt_q == lag2));
			pwm_phase_en_q <= conv_on_q ?
				phase_enables(interleave_q[`INT_PHS_MSB:`INT_PHS_LSB]) : 4'h0;
			switch_freq_1mhz_q <= freq_hi;
		end
	end

	// ****************************************
	// register reads
	// ****************************************
	always @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			reg_rdata_q <= 8'h00;
		else if (clk_en)
		begin
			case (reg_addr)
				`ADDR_INTERLEAVE: reg_rdata_q <= interleave_q;
				`ADDR_STATUS: reg_rdata_q <= {~sync_q[1], ~sync_q[0], status_q[5:0]};
				`ADDR_PROPAGATE: reg_rdata_q <= propagate_q;
				`ADDR_LATCHING: reg_rdata_q <= latching_q;
				`ADDR_OFFTYPE: reg_rdata_q <= offtype_q;
				default: reg_rdata_q <= 8'h00;
			endcase
		end
	end

endmodule // fault_propagation_sync_ctrl

/* File: inc/fault_sync_consts.vh */
`ifndef FAULT_SYNC_CONSTS_VH
`define FAULT_SYNC_CONSTS_VH

// ****************************************
// register offsets
// ****************************************
`define ADDR_INTERLEAVE 8'h04
`define ADDR_STATUS 8'h16
`define ADDR_PROPAGATE 8'h1c
`define ADDR_LATCHING 8'h1d
`define ADDR_OFFTYPE 8'h1e

// ****************************************
// field positions
// ****************************************
`define BIT_TW 7
`define BIT_PG 6
`define BIT_TR 5
`define BIT_OT 4
`define BIT_OC 3
`define BIT_UV 2
`define BIT_OV 1
`define BIT_RSV 0
`define INT_STEP_MSB 3
`define INT_STEP_LSB 0
`define INT_FREQ 5
`define INT_PHS_MSB 7
`define INT_PHS_LSB 6
`define INT_WRITE_MASK 8'hef

// ****************************************
// reset values
// ****************************************
`define INTERLEAVE_RESET 8'h00
`define STATUS_RESET 8'hff
`define PROPAGATE_RESET 8'h00
`define LATCHING_RESET 8'h00
`define OFFTYPE_RESET 8'h00

// ****************************************
// turn-off types
// ****************************************
`define OFF_SEQUENCED 2'h0
`define OFF_CRITICAL 2'h1
`define OFF_EMERGENCY 2'h2

// ****************************************
// timing
// ****************************************
`define RETRY_MS 130
`define CLK_KHZ 250000
`define SYNC_KHZ 500
`define PHASE_STEPS 16

`endif

/* File: sim/fault_sync_chk_asserts.sv */
`timescale 1ns/1ps
`include "fault_sync_consts.vh"
// ****
// port checker
// ****
module fault_sync_chk (
	// clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// link
	input wire sync_line,
	input wire fault_line_o_q,
	input wire fault_line_oe_n_q,
	// conditions
	input wire overcurrent_fault,
	input wire prebias_exceeded,
	// registers
	input wire reg_wr,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_rdata_q,
	// control
	input wire conv_on_q,
	input wire pwm_start_q,
	input wire [3:0] pwm_phase_en_q,
	input wire switch_freq_1mhz_q
);
default clocking cb @(posedge clk_sys); endclocking
default disable iff (sys_rst);
reg sync_q;
reg [3:0] age_q;
// cycles since the pin fell; synchroniser plus edge flop adds about 3
always @(posedge clk_sys or posedge sys_rst)
begin
	if (sys_rst)
	begin
		sync_q <= 1'b1;
		age_q <= 4'hf;
	end
	else
	begin
		sync_q <= sync_line;
		age_q <= (sync_q & ~sync_line) ? 4'h0 : ((age_q == 4'hf) ? age_q : age_q + 4'h1);
	end
end
property p_od_data;
	fault_line_o_q == 1'b0;
endproperty
a_od_data: assert property (p_od_data) else $error("fault data not low");
property p_pull_off;
	!fault_line_oe_n_q |-> !conv_on_q;
endproperty
a_pull_off: assert property (p_pull_off) else $error("pull while on");
property p_edge;
	$changed(fault_line_oe_n_q) |-> age_q <= 4'h6;
endproperty
a_edge: assert property (p_edge) else $error("drive off sync fall");
property p_oc_off;
	conv_on_q && prebias_exceeded && $rose(overcurrent_fault) |-> ##[1:6] !conv_on_q;
endproperty
a_oc_off: assert property (p_oc_off) else $error("no off on oc");
property p_bit4;
	$past(reg_addr) == `ADDR_INTERLEAVE |-> !reg_rdata_q[4];
endproperty
a_bit4: assert property (p_bit4) else $error("bit4 not zero");
property p_freq;
	$past(reg_addr) == `ADDR_INTERLEAVE && !$past(reg_wr) && !$past(reg_wr, 2)
		|-> reg_rdata_q[5] == switch_freq_1mhz_q;
endproperty
a_freq: assert property (p_freq) else $error("freq not bit5");
property p_phase_on;
	conv_on_q && $past(conv_on_q) |-> pwm_phase_en_q inside {4'h1, 4'h5, 4'h7, 4'hf};
endproperty
a_phase_on: assert property (p_phase_on) else $error("bad phase set");
property p_phase_off;
	!conv_on_q && !$past(conv_on_q) |-> pwm_phase_en_q == 4'h0;
endproperty
a_phase_off: assert property (p_phase_off) else $error("phases while off");
property p_pwm_on;
	pwm_start_q |-> conv_on_q || $past(conv_on_q);
endproperty
a_pwm_on: assert property (p_pwm_on) else $error("pwm start while off");
property p_pwm_pulse;
	pwm_start_q |=> !pwm_start_q;
endproperty
a_pwm_pulse: assert property (p_pwm_pulse) else $error("pwm start too long");
c_pull: cover property ($fell(fault_line_oe_n_q));
c_off: cover property ($fell(conv_on_q));
c_pwm: cover property (pwm_start_q);
endmodule // fault_sync_chk
bind fault_propagation_sync_ctrl fault_sync_chk chk (
	.clk_sys(clk_sys),
	.sys_rst(sys_rst),
	.sync_line(sync_line),
	.fault_line_o_q(fault_line_o_q),
	.fault_line_oe_n_q(fault_line_oe_n_q),
	.overcurrent_fault(overcurrent_fault),
	.prebias_exceeded(prebias_exceeded),
	.reg_wr(reg_wr),
	.reg_addr(reg_addr),
	.reg_rdata_q(reg_rdata_q),
	.conv_on_q(conv_on_q),
	.pwm_start_q(pwm_start_q),
	.pwm_phase_en_q(pwm_phase_en_q),
	.switch_freq_1mhz_q(switch_freq_1mhz_q)
);

/* File: sim/power_manager_model.sv */
`timescale 1ns/1ps
// ****
// power manager
// ****
module power_manager_model (
	// link pins
	output reg sync_line,
	output wire fault_line_i,
	input wire fault_line_oe_n_q,
	// bench control
	input wire sys_rst,
	input wire send,
	input wire [1:0] kind
);
reg pull_q;
reg [1:0] step_q;
// front end shut-off and crowbar are optional; never issued here
// master clock runs free, 8 clk_sys periods, each edge 1 ns after a clk_sys rise
initial
begin
	sync_line = 1'b1;
	#3;
	forever #16 sync_line = ~sync_line;
end
// pull-up: a released line reads high
assign fault_line_i = fault_line_oe_n_q & ~pull_q;
always @(negedge sync_line or posedge sys_rst)
begin
	if (sys_rst)
	begin
		pull_q <= 1'b0;
		step_q <= 2'h0;
	end
	else if (step_q == 2'h0)
	begin
		pull_q <= send;
		step_q <= {1'b0, send};
	end
	else if (step_q == 2'h1)
	begin
		pull_q <= (kind != 2'h1);
		step_q <= 2'h2;
	end
	else if (step_q == 2'h2)
	begin
		pull_q <= (kind != 2'h2);
		step_q <= 2'h3;
	end
	else
	begin
		pull_q <= send;
		step_q <= send ? 2'h3 : 2'h0;
	end
end
endmodule // power_manager_model

/* File: sim/test_fault_propagation_sync_ctrl.sv */
`timescale 1ns/1ps
`include "fault_sync_consts.vh"
`define CHK(n, e, s) begin num_checks = num_checks + 1; if ((s) !== (e)) begin errors = errors + 1; $display("wrong value %s exp %h got %h", n, e, s); end end
module test_fault_propagation_sync_ctrl;
// short retry keeps the run small
localparam RETRY = 2000;
reg clk_sys, sys_rst, reg_wr, turn_on_cmd, prebias_exceeded, send, drove;
reg [7:0] reg_addr, reg_wdata, det;
reg [1:0] warn, kind;
reg [2:0] hist;
reg [1:0] code_seen, want;
integer errors, num_checks, t0, b, p, k;
integer cyc = 0;
wire clk_en = 1'b1;
wire sync_line, fault_line_i, fault_line_o_q, fault_line_oe_n_q;
wire conv_on_q, pwm_start_q, switch_freq_1mhz_q;
wire [7:0] reg_rdata_q;
wire [1:0] shutdown_type_q;
wire [3:0] pwm_phase_en_q;
wire tracking_fault = det[5];
wire overtemp_fault = det[4];
wire overcurrent_fault = det[3];
wire undervoltage_fault = det[2];
wire overvoltage_error = det[1];
wire temp_warning = warn[1];
wire power_good_warning = warn[0];
fault_propagation_sync_ctrl #(.RETRY_CYCLES(RETRY), .SYNC_CYCLES(8)) uut (
	.clk_sys(clk_sys),
	.sys_rst(sys_rst),
	.clk_en(clk_en),
	.sync_line(sync_line),
	.fault_line_i(fault_line_i),
	.fault_line_o_q(fault_line_o_q),
	.fault_line_oe_n_q(fault_line_oe_n_q),
	.turn_on_cmd(turn_on_cmd),
	.prebias_exceeded(prebias_exceeded),
	.tracking_fault(tracking_fault),
	.overtemp_fault(overtemp_fault),
	.overcurrent_fault(overcurrent_fault),
	.undervoltage_fault(undervoltage_fault),
	.overvoltage_error(overvoltage_error),
	.temp_warning(temp_warning),
	.power_good_warning(power_good_warning),
	.reg_wr(reg_wr),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_rdata_q(reg_rdata_q),
	.conv_on_q(conv_on_q),
	.shutdown_type_q(shutdown_type_q),
	.pwm_start_q(pwm_start_q),
	.pwm_phase_en_q(pwm_phase_en_q),
	.switch_freq_1mhz_q(switch_freq_1mhz_q)
);
power_manager_model pm (
	.sync_line(sync_line),
	.fault_line_i(fault_line_i),
	.fault_line_oe_n_q(fault_line_oe_n_q),
	.sys_rst(sys_rst),
	.send(send),
	.kind(kind)
);
initial
begin
	clk_sys = 1'b0;
	forever #2 clk_sys = ~clk_sys;
end
always @(posedge clk_sys)
begin
	cyc = cyc + 1;
	if (fault_line_oe_n_q === 1'b0)
		drove = 1'b1;
end
// our drive level at each sync fall; released then pulled opens a code
always @(negedge sync_line)
begin
	hist <= {hist[1:0], fault_line_oe_n_q};
	if (hist[2:1] == 2'b10 && code_seen == 2'h3)
		code_seen <= {fault_line_oe_n_q, hist[0]};
end
// ****
// access tasks
// ****
task end_sim;
begin
	if (errors == 0 && num_checks > 0)
		$display("Test passed");
	else
		$display("Test failed");
	$finish;
end
endtask
task wr(input [7:0] a, input [7:0] d);
begin
	@(posedge clk_sys);
	reg_addr <= a;
	reg_wdata <= d;
	reg_wr <= 1'b1;
	@(posedge clk_sys);
	reg_wr <= 1'b0;
end
endtask
task rdc(input [7:0] a, input [7:0] e);
begin
	@(posedge clk_sys);
	reg_addr <= a;
	repeat (2) @(posedge clk_sys);
	#1;
	`CHK("rdata", e, reg_rdata_q)
end
endtask
task wt(input s, input v, input integer lim);
integer i;
begin
	i = 0;
	while ((s ? fault_line_oe_n_q : conv_on_q) !== v && i < lim)
	begin
		@(posedge clk_sys);
		#1;
		i = i + 1;
	end
	`CHK("wait", v, s ? fault_line_oe_n_q : conv_on_q)
	if ((s ? fault_line_oe_n_q : conv_on_q) !== v)
		end_sim;
end
endtask
function [1:0] exp_type(input integer bit_n, input integer alt);
	exp_type = (bit_n == 1) ? (alt ? 2'h2 : 2'h1) : (bit_n == 3 || bit_n == 5) ? 2'h1
		: (alt ? 2'h1 : 2'h0);
endfunction
// ****
// sequence
// ****
initial
begin
	errors = 0;
	num_checks = 0;
	sys_rst = 1'b1;
	reg_wr = 1'b0;
	reg_addr = 8'h00;
	reg_wdata = 8'h00;
	turn_on_cmd = 1'b0;
	prebias_exceeded = 1'b1;
	det = 8'h00;
	warn = 2'h0;
	send = 1'b0;
	kind = 2'h0;
	drove = 1'b0;
	repeat (16) @(posedge clk_sys);
	sys_rst <= 1'b0;
	rdc(8'h04, 8'h00);
	rdc(8'h1c, 8'h00);
	rdc(8'h33, 8'h00);
	@(posedge clk_sys) warn <= 2'h3;
	repeat (4) @(posedge clk_sys);
	rdc(8'h16, 8'h3f);
	@(posedge clk_sys) warn <= 2'h0;
	wr(8'h04, 8'hff);
	rdc(8'h04, 8'hef);
	`CHK("freq", 1'b1, switch_freq_1mhz_q)
	wr(8'h04, 8'h42);
	wr(8'h1c, 8'h3e);
	rdc(8'h1c, 8'h3e);
	@(posedge clk_sys) turn_on_cmd <= 1'b1;
	wt(0, 1'b1, 200);
	// one start per sync period, 8 clocks each
	k = 0;
	repeat (32)
	begin
		@(posedge clk_sys);
		#1;
		k = k + pwm_start_q;
	end
	`CHK("pwm", 4, k)
	`CHK("phases", 4'h5, pwm_phase_en_q)
	`CHK("freq", 1'b0, switch_freq_1mhz_q)
	wr(8'h04, 8'hc0);
	rdc(8'h04, 8'h42);
	// overcurrent below prebias must not trip
	@(posedge clk_sys) prebias_exceeded <= 1'b0;
	@(posedge clk_sys) det <= 8'h08;
	repeat (20) @(posedge clk_sys);
	#1;
	`CHK("armed", 1'b1, conv_on_q)
	@(posedge clk_sys) det <= 8'h00;
	prebias_exceeded <= 1'b1;
	repeat (6) @(posedge clk_sys);
	for (p = 0; p < 2; p = p + 1)
	begin
		wr(8'h1e, p ? 8'h16 : 8'h00);
		for (b = 1; b < 6; b = b + 1)
		begin
			@(posedge clk_sys) det <= 8'h01 << b;
			t0 = cyc;
			code_seen = 2'h3;
			want = {exp_type(b, p) == 2'h2, exp_type(b, p) == 2'h1};
			wt(0, 1'b0, 20);
			`CHK("type", exp_type(b, p), shutdown_type_q)
			rdc(8'h16, ~(8'h01 << b));
			wt(1, 1'b0, 40);
			repeat (24) @(posedge clk_sys);
			`CHK("code", want, code_seen)
			@(posedge clk_sys) det <= 8'h00;
			wt(0, 1'b1, RETRY + 400);
			`CHK("retry", 1'b1, cyc - t0 >= RETRY && cyc - t0 < RETRY + 60)
		end
	end
	wr(8'h1c, 8'h2e);
	wr(8'h1d, 8'h10);
	drove = 1'b0;
	@(posedge clk_sys) det <= 8'h10;
	wt(0, 1'b0, 20);
	@(posedge clk_sys) det <= 8'h00;
	repeat (RETRY + 200) @(posedge clk_sys);
	#1;
	`CHK("latched", 1'b0, conv_on_q)
	`CHK("drove", 1'b0, drove)
	wr(8'h16, 8'h10);
	wt(0, 1'b1, 200);
	wr(8'h1d, 8'h00);
	for (k = 0; k < 3; k = k + 1)
	begin
		@(posedge clk_sys) kind <= k[1:0];
		@(posedge clk_sys) send <= 1'b1;
		wt(0, 1'b0, 200);
		`CHK("remote", k[1:0], shutdown_type_q)
		@(posedge clk_sys) send <= 1'b0;
		wt(0, 1'b1, 200);
	end
	end_sim;
end
endmodule // test_fault_propagation_sync_ctrl
